// File: hw/cfp_pkg.sv
package cfp_pkg;

    // widths
    localparam int PC_W    = 21;
    localparam int INST_W  = 16;
    localparam int DADDR_W = 12;
    localparam int DDATA_W = 8;
    localparam int BANK_W  = 4;
    localparam int OFFS_W  = 8;
    localparam int REG_AW  = 8;
    localparam int REG_DW  = 32;
    localparam int NUM_PTR = 3;
    localparam int NUM_BANKS = 16;

    // reset values
    localparam logic [PC_W-1:0]    PC_RST   = 21'h000000;
    localparam logic [BANK_W-1:0]  BANK_RST = 4'h0;
    localparam logic [DDATA_W-1:0] WORK_RST = 8'h00;
    localparam logic [INST_W-1:0]  NOP_WORD = 16'h0000;

    // program counter steps one instruction word of two bytes
    localparam logic [PC_W-1:0]    PC_STEP  = 21'h000002;

    // fast-access map split and the banks it lands in
    localparam logic [OFFS_W-1:0]  ACCESS_SPLIT   = 8'h80;
    localparam logic [BANK_W-1:0]  ACCESS_LO_BANK = 4'h0;
    localparam logic [BANK_W-1:0]  ACCESS_HI_BANK = 4'hf;

    // tag in the top four bits of every second instruction word
    localparam logic [3:0]         SECOND_TAG = 4'hf;

    // register offsets (byte addresses)
    localparam logic [REG_AW-1:0]  OFS_BANK_SELECT = 8'h00;
    localparam logic [REG_AW-1:0]  OFS_WORKING     = 8'h04;
    localparam logic [REG_AW-1:0]  OFS_STATUS      = 8'h08;
    localparam logic [REG_AW-1:0]  OFS_PC          = 8'h0c;
    localparam logic [REG_AW-1:0]  OFS_LATCH       = 8'h10;
    localparam logic [REG_AW-1:0]  OFS_PTR0        = 8'h14;
    localparam logic [REG_AW-1:0]  OFS_PTR1        = 8'h18;
    localparam logic [REG_AW-1:0]  OFS_PTR2        = 8'h1c;

    // opcode patterns
    localparam logic [7:0] OPC_JUMP      = 8'hef;
    localparam logic [6:0] OPC_CALL      = 7'h76;
    localparam logic [3:0] OPC_MOVE      = 4'hc;
    localparam logic [9:0] OPC_LOAD_PTR  = 10'h3b8;
    localparam logic [11:0] OPC_LOAD_BANK = 12'h010;
    localparam logic [7:0] OPC_LOAD_W    = 8'h0e;
    localparam logic [5:0] OPC_ADD_W     = 6'h09;
    localparam logic [6:0] OPC_STORE_W   = 7'h37;
    localparam logic [6:0] OPC_TEST_SKIP = 7'h33;
    localparam logic [4:0] OPC_BRANCH    = 5'h1a;

    typedef enum logic [3:0] {
        PH_FIRST  = 4'b0001,
        PH_SECOND = 4'b0010,
        PH_THIRD  = 4'b0100,
        PH_FOURTH = 4'b1000
    } cfp_phase_t;

    typedef enum logic [3:0] {
        OP_NOP       = 4'h0,
        OP_LOAD_W    = 4'h1,
        OP_LOAD_BANK = 4'h2,
        OP_ADD_W     = 4'h3,
        OP_STORE_W   = 4'h4,
        OP_TEST_SKIP = 4'h5,
        OP_BRANCH    = 4'h6,
        OP_JUMP      = 4'h7,
        OP_CALL      = 4'h8,
        OP_MOVE      = 4'h9,
        OP_LOAD_PTR  = 4'ha
    } cfp_op_t;

    function automatic cfp_op_t cfp_decode(input logic [INST_W-1:0] word);
        cfp_op_t op;
        op = OP_NOP;
        if (word[15:8] == OPC_JUMP)
            op = OP_JUMP;
        else if (word[15:9] == OPC_CALL)
            op = OP_CALL;
        else if (word[15:12] == OPC_MOVE)
            op = OP_MOVE;
        else if (word[15:6] == OPC_LOAD_PTR)
            op = OP_LOAD_PTR;
        else if (word[15:4] == OPC_LOAD_BANK)
            op = OP_LOAD_BANK;
        else if (word[15:8] == OPC_LOAD_W)
            op = OP_LOAD_W;
        else if (word[15:10] == OPC_ADD_W)
            op = OP_ADD_W;
        else if (word[15:9] == OPC_STORE_W)
            op = OP_STORE_W;
        else if (word[15:9] == OPC_TEST_SKIP)
            op = OP_TEST_SKIP;
        else if (word[15:11] == OPC_BRANCH)
            op = OP_BRANCH;
        return op;
    endfunction : cfp_decode

    function automatic logic cfp_two_word(input cfp_op_t op);
        return (op == OP_JUMP) || (op == OP_CALL) || (op == OP_MOVE) || (op == OP_LOAD_PTR);
    endfunction : cfp_two_word

    // banked or fast-access data address from the access bit and 8-bit operand
    function automatic logic [DADDR_W-1:0] cfp_bank_addr(
        input logic              banked,
        input logic [OFFS_W-1:0] offs,
        input logic [BANK_W-1:0] bank
    );
        logic [BANK_W-1:0] hi;
        hi = ACCESS_LO_BANK;
        if (banked)
            hi = bank;
        else if (offs >= ACCESS_SPLIT)
            hi = ACCESS_HI_BANK;
        return {hi, offs};
    endfunction : cfp_bank_addr

endpackage : cfp_pkg

// File: hw/cfp_phase_gen.sv
`timescale 1ns/10ps

// divides the core clock into four one-hot phases
module cfp_phase_gen (
    input  wire logic                sys_clk_in,
    input  wire logic                resetn_in,
    output cfp_pkg::cfp_phase_t      phase_out
);

    typedef struct packed {
        cfp_pkg::cfp_phase_t phase;
    } cfp_phase_st_t;

    cfp_phase_st_t st_q;
    cfp_phase_st_t st_d;

    always_comb
    begin
        st_d = st_q;
        unique case (st_q.phase)
            cfp_pkg::PH_FIRST:  st_d.phase = cfp_pkg::PH_SECOND;
            cfp_pkg::PH_SECOND: st_d.phase = cfp_pkg::PH_THIRD;
            cfp_pkg::PH_THIRD:  st_d.phase = cfp_pkg::PH_FOURTH;
            cfp_pkg::PH_FOURTH: st_d.phase = cfp_pkg::PH_FIRST;
            default:            st_d.phase = cfp_pkg::PH_FIRST;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            st_q.phase <= cfp_pkg::PH_FIRST;
        else
            st_q <= st_d;
    end

    assign phase_out = st_q.phase;

endmodule : cfp_phase_gen

// File: hw/cfp_core.sv
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps

// Operation
// RULE1 - clock divided into four one-hot phases
// RULE2 - counter advances first phase, fetch fourth
// RULE3 - latch loads first phase, executes afterwards
// RULE4 - operand read second, write fourth phase
// RULE5 - fetch overlaps execute, one per cycle
// RULE6 - counter change flushes fetched word, two cycles
// RULE7 - byte addressed, counter steps two, bit0 zero
// RULE8 - absolute word address loads counter bits 20:1
// RULE9 - relative offset counts words, doubled bytes
// RULE10 - four two-word instructions recognised
// RULE11 - second word tagged 1111, 12-bit literal
// RULE12 - tagged word alone acts as no-operation
// RULE13 - 12-bit data address, sixteen 256-byte banks
// RULE14 - unimplemented locations read as zero
// RULE15 - fast-access region skips bank select
// RULE16 - bank select supplies upper four bits
// RULE17 - bank select upper bits read zero
// RULE18 - load bank literal writes bank select
// RULE19 - unimplemented bank: drop write, zero, flags
// RULE20 - register move uses full 12-bit addresses
// RULE21 - access bit picks banked or fast map
// RULE22 - second word held for paired execution
module cfp_core #(
    parameter logic [cfp_pkg::NUM_BANKS-1:0] IMPL_BANKS = 16'hffff
) (
    input  wire logic                          sys_clk_in,
    input  wire logic                          resetn_in,
    output logic [cfp_pkg::PC_W-1:0]           pm_addr_out,
    input  wire logic [cfp_pkg::INST_W-1:0]    pm_data_in,
    output logic [cfp_pkg::DADDR_W-1:0]        dm_addr_out,
    output logic                               dm_rd_out,
    input  wire logic [cfp_pkg::DDATA_W-1:0]   dm_rdata_in,
    output logic                               dm_wr_out,
    output logic [cfp_pkg::DDATA_W-1:0]        dm_wdata_out,
    output cfp_pkg::cfp_phase_t                phase_out,
    input  wire logic [cfp_pkg::REG_AW-1:0]    reg_addr_in,
    input  wire logic [cfp_pkg::REG_DW-1:0]    reg_wdata_in,
    input  wire logic                          reg_wr_in,
    input  wire logic                          reg_rd_in,
    output logic [cfp_pkg::REG_DW-1:0]         reg_rdata_out
);

    typedef struct packed {
        logic [cfp_pkg::PC_W-1:0]                            pc;
        logic [cfp_pkg::PC_W-1:0]                            pm_addr;
        logic [cfp_pkg::INST_W-1:0]                          fetch;
        logic                                                fetch_flush;
        logic [cfp_pkg::INST_W-1:0]                          latch;
        logic                                                latch_valid;
        logic [cfp_pkg::INST_W-1:0]                          first;
        logic                                                paired;
        logic [cfp_pkg::BANK_W-1:0]                          bank;
        logic [cfp_pkg::DDATA_W-1:0]                         work;
        logic                                                zero;
        logic                                                carry;
        logic [cfp_pkg::DDATA_W-1:0]                         operand;
        logic [cfp_pkg::DDATA_W-1:0]                         move_hold;
        logic [cfp_pkg::NUM_PTR-1:0][cfp_pkg::DADDR_W-1:0]   ptr;
        logic [cfp_pkg::DADDR_W-1:0]                         dm_addr;
        logic                                                dm_rd;
        logic                                                dm_wr;
        logic [cfp_pkg::DDATA_W-1:0]                         dm_wdata;
        logic [cfp_pkg::REG_DW-1:0]                          rdata;
    } cfp_core_st_t;

    cfp_core_st_t        st_q;
    cfp_core_st_t        st_d;
    cfp_pkg::cfp_phase_t phase;

    cfp_phase_gen u_phase (
        .sys_clk_in (sys_clk_in),
        .resetn_in  (resetn_in),
        .phase_out  (phase)
    ); // RULE1

    function automatic logic bank_ok(input logic [cfp_pkg::DADDR_W-1:0] addr);
        return IMPL_BANKS[addr[cfp_pkg::DADDR_W-1 -: cfp_pkg::BANK_W]];
    endfunction : bank_ok

    always_comb
    begin
        cfp_pkg::cfp_op_t             op_next;
        cfp_pkg::cfp_op_t             op_cur;
        cfp_pkg::cfp_op_t             op_first;
        logic [cfp_pkg::DDATA_W-1:0]  rd_val;
        logic [cfp_pkg::DDATA_W:0]    sum;
        logic [cfp_pkg::PC_W-1:0]     disp;
        op_next  = cfp_pkg::OP_NOP;
        op_cur   = cfp_pkg::OP_NOP;
        op_first = cfp_pkg::cfp_decode(st_q.first);
        rd_val   = '0;
        sum      = '0;
        disp     = '0;

        st_d          = st_q;
        st_d.dm_rd    = 1'b0;
        st_d.dm_wr    = 1'b0;
        st_d.rdata    = '0;

        // a tagged word executes only as partner of its first word
        if (st_q.latch_valid && !st_q.paired)
            op_cur = cfp_pkg::cfp_decode(st_q.latch); // RULE12

        unique case (phase)
            cfp_pkg::PH_FIRST:
            begin
                st_d.pm_addr = st_q.pc;
                st_d.pc      = st_q.pc + cfp_pkg::PC_STEP; // RULE2 RULE7
                st_d.latch       = st_q.fetch_flush ? cfp_pkg::NOP_WORD : st_q.fetch; // RULE3 RULE6
                st_d.latch_valid = !st_q.fetch_flush;
                st_d.first       = st_q.latch; // RULE22
                st_d.paired      = st_q.latch_valid && !st_q.paired && !st_q.fetch_flush
                                   && cfp_pkg::cfp_two_word(cfp_pkg::cfp_decode(st_q.latch))
                                   && (st_q.fetch[15:12] == cfp_pkg::SECOND_TAG); // RULE10 RULE11 RULE22
                if (!st_q.fetch_flush && !st_d.paired)
                    op_next = cfp_pkg::cfp_decode(st_q.fetch);
                unique case (op_next)
                    cfp_pkg::OP_ADD_W, cfp_pkg::OP_TEST_SKIP:
                    begin
                        st_d.dm_rd   = 1'b1; // RULE4
                        st_d.dm_addr = cfp_pkg::cfp_bank_addr(st_q.fetch[8], st_q.fetch[7:0],
                                                              st_q.bank); // RULE15 RULE16 RULE21
                    end
                    cfp_pkg::OP_MOVE:
                    begin
                        st_d.dm_rd   = 1'b1;
                        st_d.dm_addr = st_q.fetch[cfp_pkg::DADDR_W-1:0]; // RULE20
                    end
                    default:
                    begin
                    end
                endcase
            end
            cfp_pkg::PH_SECOND:
            begin
            end
            cfp_pkg::PH_THIRD:
            begin
                // read data stands in the cycle after the strobe
                if (bank_ok(st_q.dm_addr))
                    rd_val = dm_rdata_in; // RULE13
                else
                    rd_val = '0; // RULE14 RULE19
                st_d.operand = rd_val;
                sum = {1'b0, st_q.work} + {1'b0, rd_val};
                unique case (op_cur)
                    cfp_pkg::OP_ADD_W:
                    begin
                        if (st_q.latch[9])
                        begin
                            st_d.dm_wr    = bank_ok(st_q.dm_addr); // RULE4 RULE19
                            st_d.dm_wdata = sum[cfp_pkg::DDATA_W-1:0];
                        end
                    end
                    cfp_pkg::OP_STORE_W:
                    begin
                        st_d.dm_addr  = cfp_pkg::cfp_bank_addr(st_q.latch[8], st_q.latch[7:0],
                                                               st_q.bank); // RULE16 RULE21
                        st_d.dm_wr    = bank_ok(st_d.dm_addr); // RULE19
                        st_d.dm_wdata = st_q.work;
                    end
                    cfp_pkg::OP_MOVE:
                        st_d.move_hold = rd_val;
                    default:
                    begin
                    end
                endcase
                if (st_q.paired && op_first == cfp_pkg::OP_MOVE)
                begin
                    st_d.dm_addr  = st_q.latch[cfp_pkg::DADDR_W-1:0]; // RULE20
                    st_d.dm_wr    = bank_ok(st_d.dm_addr); // RULE19
                    st_d.dm_wdata = st_q.move_hold;
                end
            end
            cfp_pkg::PH_FOURTH:
            begin
                // next word captured while the current one finishes
                st_d.fetch       = pm_data_in; // RULE2 RULE5
                st_d.fetch_flush = 1'b0;
                sum  = {1'b0, st_q.work} + {1'b0, st_q.operand};
                disp = {{(cfp_pkg::PC_W-12){st_q.latch[10]}}, st_q.latch[10:0], 1'b0}; // RULE9
                if (st_q.paired && op_first == cfp_pkg::OP_LOAD_PTR
                    && st_q.first[5:4] < 2'(cfp_pkg::NUM_PTR))
                    st_d.ptr[st_q.first[5:4]] = {st_q.first[3:0], st_q.latch[7:0]}; // RULE11
                unique case (op_cur)
                    cfp_pkg::OP_LOAD_W:
                        st_d.work = st_q.latch[7:0];
                    cfp_pkg::OP_LOAD_BANK:
                        st_d.bank = st_q.latch[cfp_pkg::BANK_W-1:0]; // RULE18
                    cfp_pkg::OP_ADD_W:
                    begin
                        // flags follow the result even when the bank is absent
                        st_d.zero  = (sum[cfp_pkg::DDATA_W-1:0] == '0); // RULE19
                        st_d.carry = sum[cfp_pkg::DDATA_W];
                        if (!st_q.latch[9])
                            st_d.work = sum[cfp_pkg::DDATA_W-1:0];
                    end
                    cfp_pkg::OP_TEST_SKIP:
                    begin
                        // discarding the fetched word skips it
                        if (st_q.operand == '0)
                            st_d.fetch_flush = 1'b1; // RULE12
                    end
                    cfp_pkg::OP_BRANCH:
                    begin
                        st_d.pc          = st_q.pm_addr + disp; // RULE9
                        st_d.fetch_flush = 1'b1; // RULE6
                    end
                    cfp_pkg::OP_JUMP, cfp_pkg::OP_CALL:
                    begin
                        // second word is on the fetch bus in this phase
                        st_d.pc          = {pm_data_in[11:0], st_q.latch[7:0], 1'b0}; // RULE8
                        st_d.fetch_flush = 1'b1; // RULE6
                    end
                    default:
                    begin
                    end
                endcase
            end
            default:
            begin
            end
        endcase

        // bus write lands after the instruction update and so wins
        if (reg_wr_in)
        begin
            unique case (reg_addr_in)
                cfp_pkg::OFS_BANK_SELECT: st_d.bank = reg_wdata_in[cfp_pkg::BANK_W-1:0]; // RULE17
                cfp_pkg::OFS_WORKING:     st_d.work = reg_wdata_in[cfp_pkg::DDATA_W-1:0];
                default:
                begin
                end
            endcase
        end

        if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                cfp_pkg::OFS_BANK_SELECT: st_d.rdata = {28'h0000000, st_q.bank}; // RULE17
                cfp_pkg::OFS_WORKING:     st_d.rdata = {24'h000000, st_q.work};
                cfp_pkg::OFS_STATUS:      st_d.rdata = {28'h0000000, st_q.paired, st_q.latch_valid,
                                                        st_q.carry, st_q.zero};
                cfp_pkg::OFS_PC:          st_d.rdata = {11'h000, st_q.pc};
                cfp_pkg::OFS_LATCH:       st_d.rdata = {16'h0000, st_q.latch};
                cfp_pkg::OFS_PTR0:        st_d.rdata = {20'h00000, st_q.ptr[0]};
                cfp_pkg::OFS_PTR1:        st_d.rdata = {20'h00000, st_q.ptr[1]};
                cfp_pkg::OFS_PTR2:        st_d.rdata = {20'h00000, st_q.ptr[2]};
                default:                  st_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            st_q             <= '0;
            st_q.pc          <= cfp_pkg::PC_RST;
            st_q.bank        <= cfp_pkg::BANK_RST;
            st_q.work        <= cfp_pkg::WORK_RST;
            st_q.fetch       <= cfp_pkg::NOP_WORD;
            st_q.fetch_flush <= 1'b1;
            st_q.latch       <= cfp_pkg::NOP_WORD;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign pm_addr_out   = st_q.pm_addr;
    assign dm_addr_out   = st_q.dm_addr;
    assign dm_rd_out     = st_q.dm_rd;
    assign dm_wr_out     = st_q.dm_wr;
    assign dm_wdata_out  = st_q.dm_wdata;
    assign phase_out     = phase;
    assign reg_rdata_out = st_q.rdata;

endmodule : cfp_core

// File: dv/cfp_core_asserts.sv
`timescale 1ns/10ps

module cfp_core_chk #(
    parameter logic [cfp_pkg::NUM_BANKS-1:0] IMPL_BANKS = 16'hffff
) (
    input  wire logic                          sys_clk_in,
    input  wire logic                          resetn_in,
    input  wire logic [cfp_pkg::PC_W-1:0]      pm_addr_out,
    input  wire logic [cfp_pkg::DADDR_W-1:0]   dm_addr_out,
    input  wire logic                          dm_rd_out,
    input  wire logic                          dm_wr_out,
    input  cfp_pkg::cfp_phase_t                phase_out,
    input  wire logic [cfp_pkg::REG_AW-1:0]    reg_addr_in,
    input  wire logic [cfp_pkg::REG_DW-1:0]    reg_wdata_in,
    input  wire logic                          reg_wr_in,
    input  wire logic                          reg_rd_in,
    input  wire logic [cfp_pkg::REG_DW-1:0]    reg_rdata_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);

    sequence s_bank_wr;
        reg_wr_in && reg_addr_in == cfp_pkg::OFS_BANK_SELECT;
    endsequence
    sequence s_bank_rd;
        reg_rd_in && reg_addr_in == cfp_pkg::OFS_BANK_SELECT;
    endsequence

    property p_phase_rot;
        $past(resetn_in, 2) |-> phase_out == {$past(phase_out[2:0]), $past(phase_out[3])};
    endproperty
    property p_pm_stable;
        phase_out != cfp_pkg::PH_FIRST |=> $stable(pm_addr_out);
    endproperty
    property p_pm_hold;
        $changed(pm_addr_out) |=> $stable(pm_addr_out) [*3];
    endproperty
    property p_pm_align;
        pm_addr_out[0] == 1'b0;
    endproperty
    property p_rd_phase;
        dm_rd_out |-> phase_out == cfp_pkg::PH_SECOND;
    endproperty
    property p_wr_phase;
        dm_wr_out |-> phase_out == cfp_pkg::PH_FOURTH;
    endproperty
    property p_unimpl;
        dm_wr_out |-> IMPL_BANKS[dm_addr_out[11:8]];
    endproperty
    property p_bank_rw;
        s_bank_wr ##1 s_bank_rd |=> reg_rdata_out == {28'h0, $past(reg_wdata_in[3:0], 2)};
    endproperty

    a_phase_rot: assert property (p_phase_rot) else $error("phase did not rotate");
    a_pm_stable: assert property (p_pm_stable) else $error("fetch address moved off first phase");
    a_pm_hold: assert property (p_pm_hold) else $error("fetch address held under four cycles");
    a_pm_align: assert property (p_pm_align) else $error("fetch address odd");
    a_rd_phase: assert property (p_rd_phase) else $error("data read outside second phase");
    a_wr_phase: assert property (p_wr_phase) else $error("data write outside fourth phase");
    a_unimpl: assert property (p_unimpl) else $error("write to unimplemented bank");
    a_bank_rw: assert property (p_bank_rw) else $error("bank select readback wrong");
endmodule : cfp_core_chk

bind cfp_core cfp_core_chk #(.IMPL_BANKS(IMPL_BANKS)) u_chk (.sys_clk_in, .resetn_in, .pm_addr_out,
    .dm_addr_out, .dm_rd_out, .dm_wr_out, .phase_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out);

// File: dv/cfp_mem_model.sv
`timescale 1ns/10ps

module cfp_mem_model (
    input  wire logic [cfp_pkg::PC_W-1:0]      pm_addr_in,
    output logic [cfp_pkg::INST_W-1:0]         pm_data_out,
    input  wire logic                          clk_in,
    input  wire logic [cfp_pkg::DADDR_W-1:0]   dm_addr_in,
    input  wire logic                          dm_rd_in,
    output logic [cfp_pkg::DDATA_W-1:0]        dm_rdata_out,
    input  wire logic                          dm_wr_in,
    input  wire logic [cfp_pkg::DDATA_W-1:0]   dm_wdata_in
);
    logic [15:0] pmem [64];
    logic [7:0]  dmem [4096];

    assign pm_data_out = pmem[pm_addr_in[6:1]];

    initial dm_rdata_out = 8'h00;

    // read data valid only in the cycle after the strobe, scrambled otherwise
    always @(posedge clk_in)
    begin
        if (dm_rd_in)
            dm_rdata_out <= dmem[dm_addr_in];
        else
            dm_rdata_out <= ~dm_rdata_out;
        if (dm_wr_in)
            dmem[dm_addr_in] <= dm_wdata_in;
    end
endmodule : cfp_mem_model

// File: dv/core_fetch_pipeline_bank_addressing_tb_top.sv
`timescale 1ns/10ps

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module core_fetch_pipeline_bank_addressing_tb_top;
    logic                          sys_clk_in;
    logic                          resetn_in;
    logic [cfp_pkg::PC_W-1:0]      pm_addr_out;
    logic [cfp_pkg::INST_W-1:0]    pm_data_in;
    logic [cfp_pkg::DADDR_W-1:0]   dm_addr_out;
    logic                          dm_rd_out;
    logic [cfp_pkg::DDATA_W-1:0]   dm_rdata_in;
    logic                          dm_wr_out;
    logic [cfp_pkg::DDATA_W-1:0]   dm_wdata_out;
    cfp_pkg::cfp_phase_t           phase_out;
    logic [cfp_pkg::REG_AW-1:0]    reg_addr_in;
    logic [cfp_pkg::REG_DW-1:0]    reg_wdata_in;
    logic                          reg_wr_in;
    logic                          reg_rd_in;
    logic [cfp_pkg::REG_DW-1:0]    reg_rdata_out;
    int                            fails;
    int                            check_count;
    int                            seed;
    logic [7:0]                    wv;
    logic [31:0]                   rnd;
    logic [31:0]                   rdat;
    logic [15:0]                   prog [25];

    // bank 3 left unimplemented
    cfp_core #(.IMPL_BANKS(16'hfff7)) DUT (.sys_clk_in, .resetn_in, .pm_addr_out, .pm_data_in,
        .dm_addr_out, .dm_rd_out, .dm_rdata_in, .dm_wr_out, .dm_wdata_out, .phase_out,
        .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out);

    cfp_mem_model u_mem (.pm_addr_in(pm_addr_out), .pm_data_out(pm_data_in), .clk_in(sys_clk_in),
        .dm_addr_in(dm_addr_out), .dm_rd_in(dm_rd_out), .dm_rdata_out(dm_rdata_in),
        .dm_wr_in(dm_wr_out), .dm_wdata_in(dm_wdata_out));

    function automatic logic [7:0] pre(input int a);
        return a[7:0] ^ 8'h5a;
    endfunction : pre

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge sys_clk_in);
        reg_wr_in    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge sys_clk_in);
        reg_rd_in   <= 1'b0;
        #1;
        d = reg_rdata_out;
        @(posedge sys_clk_in);
    endtask : reg_read

    task automatic print_verdict();
        if (fails == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    initial
    begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    initial
    begin
        int n;
        resetn_in    = 1'b0;
        reg_wr_in    = 1'b0;
        reg_rd_in    = 1'b0;
        reg_addr_in  = 8'h00;
        reg_wdata_in = 32'h0;
        fails        = 0;
        check_count  = 0;
        seed         = 32'ha00f;
        wv           = 8'($random(seed));
        // bank, load, banked/fast stores, move, skip over move, add, jump, dead bank, branch, loop
        prog = '{16'h0105, 16'h0e00, 16'h6f10, 16'h6e90, 16'h6e20, 16'hc510, 16'hf7a0, 16'h6630,
                 16'hc510, 16'hf7b0, 16'h2620, 16'hef10, 16'hf000, 16'h6e40, 16'h6e40, 16'h6e40,
                 16'h0103, 16'h6f55, 16'h2555, 16'hd002, 16'h6e41, 16'h6e42, 16'h0107, 16'hef17, 16'hf000};
        prog[1] = {8'h0e, wv};
        for (int i = 0; i < 64; i++)
            u_mem.pmem[i] = (i < 25) ? prog[i] : 16'h0000;
        for (int i = 0; i < 4096; i++)
            u_mem.dmem[i] = pre(i);
        u_mem.dmem[12'h030] = 8'h00;
        repeat (4) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        n = 0;
        for (int c = 0; c < 2000 && n < 12; c++)
        begin
            @(posedge sys_clk_in);
            if (pm_addr_out === 21'h00002e)
                n++;
        end
        `CHK(n, 12)
        `CHK(u_mem.dmem[12'h510], wv)
        `CHK(u_mem.dmem[12'hf90], wv)
        `CHK(u_mem.dmem[12'h020], 8'(wv + wv))
        `CHK(u_mem.dmem[12'h7a0], wv)
        `CHK(u_mem.dmem[12'h7b0], pre(12'h7b0))
        `CHK(u_mem.dmem[12'h040], pre(12'h040))
        `CHK(u_mem.dmem[12'h041], pre(12'h041))
        `CHK(u_mem.dmem[12'h042], pre(12'h042))
        `CHK(u_mem.dmem[12'h355], pre(12'h355))
        reg_read(cfp_pkg::OFS_WORKING, rdat);
        `CHK(rdat, {24'h0, wv})
        reg_read(cfp_pkg::OFS_BANK_SELECT, rdat);
        `CHK(rdat, 32'h7)
        for (int i = 0; i < 4; i++)
        begin
            rnd = $random(seed);
            reg_write(cfp_pkg::OFS_BANK_SELECT, rnd);
            reg_read(cfp_pkg::OFS_BANK_SELECT, rdat);
            `CHK(rdat, {28'h0, rnd[3:0]})
        end
        reg_read(8'h40, rdat);
        `CHK(rdat, 32'h0)
        print_verdict();
    end
endmodule : core_fetch_pipeline_bank_addressing_tb_top
